// [hdl/blink_status_pkg.sv]
// Purpose: Shared constants and types for the channel-5 blink timer and
//          the open-circuit status register.
// Assumes: 50 MHz system clock, 8-bit register port from the I2C engine.
// Notes:   Offsets are the register addresses seen on the serial port.
package blink_status_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] BLINK_OFFSET  = 8'h30;
	localparam logic [7:0] STATUS_OFFSET = 8'h31;
	localparam logic [7:0] BLINK_RESET   = 8'h00;
	localparam logic [4:0] FLAGS_RESET   = 5'h00;
	localparam int         DARK_MSB      = 7;
	localparam int         DARK_LSB      = 4;
	localparam int         LIT_MSB       = 3;
	localparam int         LIT_LSB       = 0;
	localparam int         NUM_CHANNELS  = 5;

	// ----------------------------------------------------------------
	// Timing: one tick is the 0.125 s lit-time step
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_TIME_NS  = 125000000;
	localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
	localparam int DARK_TICKS_PER_CODE = 2;  // 0.25 s per dark code step

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_type;

	typedef enum logic {LIT, DARK} blink_state_type;

endpackage : blink_status_pkg

// [hdl/led_blink_timer_open_status.sv]
// Purpose: Channel-5 blink sequencer and sticky open-circuit flags for
//          five LED sinks, behind the serial-port register interface.
// Assumes: Open detectors, supply-present and group assignment arrive
//          from analog or other logic asynchronously and are synchronised.
// Notes:   Reads return data one cycle after the read strobe.
`timescale 1ns/1ns

// Functional notes
// - Dark-time code sits in bits 7:4; zero disables blinking.
// - Dark phase lasts code times 0.25 s.
// - Lit-time code in bits 3:0; lit phase lasts (code+1) times 0.125 s.
// - While channel 5 is in the grouped backlight, it is driven steadily.
// - Both blink fields reset to zero, blinking disabled.
// - Status bits 4:0 are open flags for channels 1..5; bits 7:5 read 0.
// - Writing 1 clears a flag; a supply power cycle clears all flags.
module led_blink_timer_open_status
	import blink_status_pkg::*;
#(
	parameter int TICK_LEN = blink_status_pkg::TICK_CYCLES
) (
	input  wire logic                       sys_clk,
	input  wire logic                       rst,
	input  wire blink_status_pkg::reg_req_type reg_req,
	output logic [7:0]                      reg_rdata_ff,
	input  wire logic [4:0]                 open_detect,
	input  wire logic                       usb_supply_present,
	input  wire logic                       ch5_grouped,
	output logic                            ch5_drive_ff
);
	import blink_status_pkg::*;

	localparam int DIV_W = $clog2(TICK_LEN);

	logic [7:0]            blink_ff;
	logic [4:0]            flags_ff;
	logic [6:0]            sync1_ff;
	logic [6:0]            sync2_ff;
	logic [6:0]            sync3_ff;
	logic [6:0]            filt_ff;
	logic [DIV_W-1:0]      div_ff;
	logic                  tick;
	logic [4:0]            tick_cnt_ff;
	blink_state_type       state_ff;
	logic [3:0]            dark_code;
	logic [3:0]            lit_code;
	logic [4:0]            dark_target;
	logic [4:0]            lit_target;
	logic                  running;
	logic                  blink_wr;
	logic                  status_wr;
	logic [4:0]            open_f;
	logic                  supply_ok;
	logic                  grouped_f;
	logic [4:0]            wr_mask;

	// ------------------------------------------------------------
	// Input synchronisers and agreement filter
	// ------------------------------------------------------------
	// Three stages; the filtered level follows once stages 2 and 3 agree
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1_ff <= 7'h00;
			sync2_ff <= 7'h00;
			sync3_ff <= 7'h00;
		end else begin
			sync1_ff <= {ch5_grouped, usb_supply_present, open_detect};
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	generate
		for (genvar i = 0; i < 7; i++) begin : g_filt
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					filt_ff[i] <= 1'b0;
				end else if (sync2_ff[i] == sync3_ff[i]) begin
					filt_ff[i] <= sync3_ff[i];
				end
			end
		end
	endgenerate

	assign open_f    = filt_ff[4:0];
	assign supply_ok = filt_ff[5];
	assign grouped_f = filt_ff[6];

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	assign blink_wr  = reg_req.wr && (reg_req.addr == BLINK_OFFSET);
	assign status_wr = reg_req.wr && (reg_req.addr == STATUS_OFFSET);
	// Clear mask of a status write; zero when no status write is present
	assign wr_mask   = status_wr ? reg_req.wdata[4:0] : 5'h00;

	// Blink timing register, cleared to blinking disabled
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			blink_ff <= BLINK_RESET;
		end else if (blink_wr) begin
			blink_ff <= reg_req.wdata;
		end
	end

	// Open flags: detection sets, write-one clears, set wins over clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flags_ff <= FLAGS_RESET;
		end else if (!supply_ok) begin
			flags_ff <= FLAGS_RESET;
		end else begin
			flags_ff <= (flags_ff & ~wr_mask)
				| open_f;
		end
	end

	// Read data; unmapped addresses read as zero
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata_ff <= 8'h00;
		end else if (reg_req.rd) begin
			case (reg_req.addr)
				BLINK_OFFSET:  reg_rdata_ff <= blink_ff;
				STATUS_OFFSET: reg_rdata_ff <= {3'h0, flags_ff};
				default:       reg_rdata_ff <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Blink sequencer
	// ------------------------------------------------------------
	assign dark_code   = blink_ff[DARK_MSB:DARK_LSB];
	assign lit_code    = blink_ff[LIT_MSB:LIT_LSB];
	assign dark_target = 5'(dark_code * DARK_TICKS_PER_CODE);
	assign lit_target  = 5'(lit_code) + 5'h01;
	assign running     = (dark_code != 4'h0) && !grouped_f;
	assign tick        = (div_ff == DIV_W'(TICK_LEN - 1));

	// 0.125 s tick divider, restarted with each new sequence
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div_ff <= '0;
		end else if (!running || blink_wr || tick) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + DIV_W'(1);
		end
	end

	// Lit and dark phases counted in ticks
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff    <= LIT;
			tick_cnt_ff <= 5'h00;
		end else if (!running || blink_wr) begin
			state_ff    <= LIT;
			tick_cnt_ff <= 5'h00;
		end else if (tick) begin
			case (state_ff)
				LIT: begin
					if (tick_cnt_ff == lit_target - 5'h01) begin
						state_ff    <= DARK;
						tick_cnt_ff <= 5'h00;
					end else begin
						tick_cnt_ff <= tick_cnt_ff + 5'h01;
					end
				end
				DARK: begin
					if (tick_cnt_ff == dark_target - 5'h01) begin
						state_ff    <= LIT;
						tick_cnt_ff <= 5'h00;
					end else begin
						tick_cnt_ff <= tick_cnt_ff + 5'h01;
					end
				end
				default: begin
					state_ff    <= LIT;
					tick_cnt_ff <= 5'h00;
				end
			endcase
		end
	end

	// Sink gate: steady on unless blinking and in the dark phase
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ch5_drive_ff <= 1'b1;
		end else begin
			ch5_drive_ff <= !(running && state_ff == DARK);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// Checked on the first edge after release, once every flop has settled
	reset_fields_a: assert property (
		@(posedge sys_clk) $fell(rst) |-> blink_ff == BLINK_RESET)
		else $error("blink fields not zero after reset");

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	disabled_steady_a: assert property (
		(dark_code == 4'h0) ##1 (dark_code == 4'h0) |-> ch5_drive_ff)
		else $error("channel dark while blinking disabled");

	grouped_steady_a: assert property (
		grouped_f ##1 grouped_f |-> ch5_drive_ff)
		else $error("grouped channel not driven steadily");

	dark_len_a: assert property (
		(running && state_ff == DARK) |-> tick_cnt_ff < dark_target)
		else $error("dark phase overran its code");

	lit_len_a: assert property (
		(running && state_ff == LIT && !blink_wr) |->
		tick_cnt_ff <= 5'(lit_code))
		else $error("lit phase overran its code");

	phase_swap_a: assert property (
		(running && !blink_wr && tick && state_ff == LIT &&
		tick_cnt_ff == 5'(lit_code)) |=> state_ff == DARK ##1 !ch5_drive_ff)
		else $error("lit phase did not end on time");

	flag_sticky_a: assert property (
		(supply_ok && !status_wr) |=>
		((flags_ff & $past(flags_ff)) == $past(flags_ff)))
		else $error("open flag lost without a clear");

	set_wins_a: assert property (
		supply_ok |=> ((flags_ff & $past(open_f)) == $past(open_f)))
		else $error("detected open not flagged");

	w1c_clear_a: assert property (
		(status_wr && supply_ok) |=>
		((flags_ff & $past(wr_mask) & ~$past(open_f)) == 5'h00))
		else $error("written flag not cleared");

	power_clear_a: assert property (
		!supply_ok |=> flags_ff == 5'h00)
		else $error("flags survive supply loss");

	read_status_a: assert property (
		(reg_req.rd && reg_req.addr == STATUS_OFFSET) |=>
		reg_rdata_ff == {3'h0, $past(flags_ff)})
		else $error("status read mismatch");

	blink_cycle_c: cover property (
		running && state_ff == DARK ##1 state_ff == LIT);
	flag_clear_c: cover property (
		flags_ff != 5'h00 ##1 status_wr ##1 flags_ff == 5'h00);
	grouped_c: cover property (running ##1 grouped_f);

endmodule : led_blink_timer_open_status

// [tb/host_model.sv]
// Purpose: Serial-port host stand-in issuing register requests.
// Assumes: Strobes last one cycle, launched just after a rising edge.
// Notes:   Read data is taken at the edge after the read strobe.
`timescale 1ns/1ns
module host_model
	import blink_status_pkg::*;
(
	input  wire logic                     sys_clk,
	output blink_status_pkg::reg_req_type reg_req,
	input  wire logic [7:0]               reg_rdata_ff
);
	initial reg_req = '0;

	// One write strobe, then idle
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
		reg_req <= '0;
	endtask : wr_reg

	// One read strobe; data picked up once the answer edge has landed
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge sys_clk);
		reg_req <= '0;
		#1;
		d = reg_rdata_ff;
	endtask : rd_reg

	// Ones in the mask clear the matching open flags
	task automatic clear_flags(input logic [7:0] m);
		wr_reg(STATUS_OFFSET, m);
	endtask : clear_flags
endmodule : host_model

// [tb/led_blink_timer_open_status_tb_top.sv]
// Purpose: Self-checking bench for blink timing and open flags.
// Assumes: Tick shortened to 4 cycles; clock 50 MHz.
// Notes:   Steady drive is judged by a run that reaches the cap.
`timescale 1ns/1ns
module led_blink_timer_open_status_tb_top;
	import blink_status_pkg::*;
	localparam int TL  = 4;
	localparam int CAP = 300;
	logic                          sys_clk, rst, usb_supply_present;
	logic                          ch5_grouped, ch5_drive_ff;
	logic [4:0]                    open_detect;
	logic [7:0]                    reg_rdata_ff, rv;
	blink_status_pkg::reg_req_type reg_req;
	int                            n_mismatch = 0;
	int                            n_checks = 0;
	int                            n;

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	led_blink_timer_open_status #(.TICK_LEN(TL)) dut (
		.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
		.reg_rdata_ff(reg_rdata_ff), .open_detect(open_detect),
		.usb_supply_present(usb_supply_present),
		.ch5_grouped(ch5_grouped), .ch5_drive_ff(ch5_drive_ff));

	host_model host (.sys_clk(sys_clk), .reg_req(reg_req),
		.reg_rdata_ff(reg_rdata_ff));

	// ------------------------------------------------------------
	// Compare and measure helpers
	// ------------------------------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t byte %h not %h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk_len(input int got, input int exp);
		n_checks++;
		if (got != exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t run %0d not %0d", $time, got, exp);
		end
	endtask : chk_len

	// Counts edges while the drive keeps the given level
	task automatic run_len(input logic lvl, output int c);
		c = 0;
		while (ch5_drive_ff === lvl && c < CAP) begin
			@(posedge sys_clk);
			c++;
		end
	endtask : run_len

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic blink_case(input logic [7:0] code);
		int dk;
		int lt;
		host.wr_reg(BLINK_OFFSET, code);
		host.rd_reg(BLINK_OFFSET, rv);
		chk8(rv, code);
		run_len(1'b1, n);
		run_len(1'b0, dk);
		run_len(1'b1, lt);
		chk_len(dk, code[7:4] * 2 * TL);
		chk_len(lt, (code[3:0] + 1) * TL);
	endtask : blink_case

	task automatic steady_case(input logic [7:0] code, input logic grp);
		host.wr_reg(BLINK_OFFSET, code);
		ch5_grouped <= grp;
		repeat (8) @(posedge sys_clk);
		run_len(1'b1, n);
		chk_len(n, CAP);
		ch5_grouped <= 1'b0;
	endtask : steady_case

	task automatic flag_case();
		@(posedge sys_clk);
		open_detect <= 5'h1f;
		repeat (8) @(posedge sys_clk);
		open_detect <= 5'h00;
		repeat (8) @(posedge sys_clk);
		host.rd_reg(STATUS_OFFSET, rv);
		chk8(rv, 8'h1f);
		host.clear_flags(8'he5);
		host.rd_reg(STATUS_OFFSET, rv);
		chk8(rv, 8'h1a);
		host.rd_reg(8'h40, rv);
		chk8(rv, 8'h00);
		usb_supply_present <= 1'b0;
		repeat (8) @(posedge sys_clk);
		usb_supply_present <= 1'b1;
		repeat (8) @(posedge sys_clk);
		host.rd_reg(STATUS_OFFSET, rv);
		chk8(rv, 8'h00);
		// A clear while the channel is still open leaves its flag set
		open_detect <= 5'h10;
		repeat (8) @(posedge sys_clk);
		host.clear_flags(8'h1f);
		host.rd_reg(STATUS_OFFSET, rv);
		chk8(rv, 8'h10);
		open_detect <= 5'h00;
	endtask : flag_case

	// Blink register reads zero and the sink stays on after reset
	task automatic reset_case();
		host.rd_reg(BLINK_OFFSET, rv);
		chk8(rv, BLINK_RESET);
		run_len(1'b1, n);
		chk_len(n, CAP);
	endtask : reset_case

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	// Watchdog well past the expected 1300 or so cycles
	initial begin
		#400000;
		n_mismatch++;
		complete_run();
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		open_detect = 5'h00;
		usb_supply_present = 1'b1;
		ch5_grouped = 1'b0;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (6) @(posedge sys_clk);
		reset_case();
		blink_case(8'h1f);
		blink_case(8'hf0);
		steady_case(8'h05, 1'b0);
		steady_case(8'h11, 1'b1);
		flag_case();
		complete_run();
	end
endmodule : led_blink_timer_open_status_tb_top
